// [src/fsp_status_protect.sv]
// Status register, write latch and protection gate of a serial flash.
// Assumes SPI mode 0 on the pins, sck far slower than i_clk, and an
// array engine that asks leave through i_op_req and reports i_op_done.
// Function
// - Status read is served anytime, never disturbing a running cycle.
// - Status byte repeats while chip select stays low after read command.
// - Busy reads one during status write, program or erase.
// - Latch field mirrors the internal write enable latch.
// - Latch clear rejects status write, program and erase.
// - Size bits are persistent, status write only, select shielded area.
// - Program or sector erase inside shielded area is refused.
// - Size bits accept new values only outside locked mode.
// - Whole-array erase only with all size bits zero.
// - Bottom bit persistent, written by status write after latch set.
// - Bottom bit zero shields from the top of the array down.
// - Bottom bit frozen while lock bit set and protect pin low.
// - Locked mode is lock bit one with protect pin low.
// - Locked mode freezes lock and size bits, refuses status write.
// - Chip select rise after accepted write starts timed update, then clears latch.
// - Spare bit reads zero; write leaves spare, busy, latch alone.
// - Latch clears at reset and after any write-type completion or disable.
// - Only raising the protect pin or a reset leaves locked mode.
`timescale 1ns/1ns
`default_nettype none
`include "fsp_map.svh"

module fsp_status_protect #(
    parameter int unsigned WRITE_CYCLES = `FSP_WRITE_CYCLES,
    parameter int unsigned ADDR_W = 22,
    parameter int unsigned SECTOR_W = 16
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_spi_sck,
    input wire logic i_spi_cs_n,
    input wire logic i_spi_mosi,
    input wire logic i_write_protect_n,
    output logic o_spi_miso,
    output logic o_spi_miso_oe,
    input wire logic i_write_enable,
    input wire logic i_write_disable,
    input wire logic i_op_req,
    input wire fsp_pkg::fsp_op_e i_op_kind,
    input wire logic [ADDR_W-1:0] i_op_addr,
    input wire logic i_op_done,
    output logic o_op_grant,
    output logic o_op_reject,
    output logic o_write_busy_flag,
    output logic o_write_enable_latch,
    output logic o_hardware_locked_mode,
    output fsp_pkg::fsp_nv_s o_protect
);
    localparam int unsigned IW = ADDR_W - SECTOR_W;

    logic sck_s, cs_n_s, mosi_s, wp_n_s;
    logic sck_d_reg, sck_d_next, cs_d_reg, cs_d_next;
    fsp_pkg::fsp_phase_e phase_reg, phase_next;
    logic [2:0] bit_reg, bit_next, obit_reg, obit_next;
    logic [7:0] shin_reg, shin_next, shout_reg, shout_next, data_reg, data_next;
    logic armed_reg, armed_next;
    logic [31:0] timer_reg, timer_next;
    logic op_busy_reg, op_busy_next;
    logic wel_reg, wel_next;
    fsp_pkg::fsp_nv_s nv_reg, nv_next;
    logic miso_next, oe_next, grant_next, reject_next, busy_next, hpm_next;
    logic rise, fall, cs_rise, busy, hardware_locked_mode, in_region, refuse;
    logic [7:0] byte_in, status_now;
    logic [IW:0] prot_cnt, sect_idx;

    fsp_sync2 #(.RESET_VAL(1'b0)) u_sync_sck (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_async(i_spi_sck), .o_sync(sck_s));
    fsp_sync2 #(.RESET_VAL(1'b1)) u_sync_cs (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_async(i_spi_cs_n), .o_sync(cs_n_s));
    fsp_sync2 #(.RESET_VAL(1'b0)) u_sync_mosi (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_async(i_spi_mosi), .o_sync(mosi_s));
    fsp_sync2 #(.RESET_VAL(1'b1)) u_sync_wp (.i_clk(i_clk), .i_reset_n(i_reset_n),
        .i_async(i_write_protect_n), .o_sync(wp_n_s));

    always_comb begin
        rise = sck_s & ~sck_d_reg;
        fall = ~sck_s & sck_d_reg;
        cs_rise = cs_n_s & ~cs_d_reg;
        busy = (timer_reg != 32'h0) | op_busy_reg;
        hardware_locked_mode = nv_reg.status_lock_bit & ~wp_n_s;
        byte_in = {shin_reg[6:0], mosi_s};
        // Spare bit six tied to zero
        status_now = {nv_reg.status_lock_bit, 1'b0, nv_reg.protect_from_bottom,
                      nv_reg.protect_size, wel_reg, busy};
        // Size code n shields 2**(n-1) sectors; code 7 covers the array
        prot_cnt = (nv_reg.protect_size == 3'h0) ? '0 :
                   ((IW+1)'(1) << (nv_reg.protect_size - 3'h1));
        sect_idx = {1'b0, i_op_addr[ADDR_W-1:SECTOR_W]};
        if (nv_reg.protect_from_bottom) begin
            in_region = sect_idx < prot_cnt;
        end else begin
            in_region = sect_idx >= (((IW+1)'(1) << IW) - prot_cnt);
        end
        if (i_op_kind == fsp_pkg::OP_BULK_ERASE) begin
            refuse = nv_reg.protect_size != 3'h0;
        end else begin
            refuse = in_region;
        end
    end

    always_comb begin
        sck_d_next = sck_s;
        cs_d_next = cs_n_s;
        phase_next = phase_reg;
        bit_next = bit_reg;
        obit_next = obit_reg;
        shin_next = shin_reg;
        shout_next = shout_reg;
        data_next = data_reg;
        armed_next = armed_reg;
        timer_next = timer_reg;
        op_busy_next = op_busy_reg;
        wel_next = wel_reg;
        nv_next = nv_reg;
        miso_next = o_spi_miso;
        oe_next = o_spi_miso_oe;
        grant_next = 1'b0;
        reject_next = 1'b0;
        if (timer_reg != 32'h0) begin
            timer_next = timer_reg - 32'h1;
            if (timer_reg == 32'h1) begin
                wel_next = 1'b0;
            end
        end
        if (op_busy_reg && i_op_done) begin
            op_busy_next = 1'b0;
            wel_next = 1'b0;
        end
        if (i_op_req) begin
            if (busy || !wel_reg || refuse) begin
                reject_next = 1'b1;
            end else begin
                grant_next = 1'b1;
                op_busy_next = 1'b1;
            end
        end
        if (i_write_disable) begin
            wel_next = 1'b0;
        end
        // Set placed last so it wins over a coincident disable; ignored while busy
        if (i_write_enable && !busy) begin
            wel_next = 1'b1;
        end
        if (cs_n_s) begin
            phase_next = fsp_pkg::PH_CMD;
            bit_next = 3'h0;
            obit_next = 3'h0;
            oe_next = 1'b0;
            armed_next = 1'b0;
            if (cs_rise && armed_reg && !busy && !hardware_locked_mode) begin
                // Busy and latch bits are not fields of the stored byte
                nv_next.status_lock_bit = data_reg[`FSP_BIT_LOCK];
                nv_next.protect_from_bottom = data_reg[`FSP_BIT_BOTTOM];
                nv_next.protect_size =
                    data_reg[`FSP_BIT_SIZE_MSB:`FSP_BIT_SIZE_LSB];
                timer_next = WRITE_CYCLES;
            end
        end else begin
            if (rise) begin
                shin_next = byte_in;
                bit_next = bit_reg + 3'h1;
                if (phase_reg == fsp_pkg::PH_SKIP) begin
                    armed_next = 1'b0;
                end
                if (bit_reg == 3'h7) begin
                    case (phase_reg)
                        fsp_pkg::PH_CMD: begin
                            if (byte_in == `FSP_CMD_READ_STATUS) begin
                                phase_next = fsp_pkg::PH_READ;
                                shout_next = status_now;
                            end else if (byte_in == `FSP_CMD_WRITE_STATUS && wel_reg &&
                                         !hardware_locked_mode && !busy) begin
                                phase_next = fsp_pkg::PH_WDATA;
                            end else begin
                                phase_next = fsp_pkg::PH_SKIP;
                            end
                        end
                        fsp_pkg::PH_WDATA: begin
                            data_next = byte_in;
                            armed_next = 1'b1;
                            phase_next = fsp_pkg::PH_SKIP;
                        end
                        default: begin
                            phase_next = phase_reg;
                        end
                    endcase
                end
            end
            if (fall && phase_reg == fsp_pkg::PH_READ) begin
                miso_next = shout_reg[7];
                oe_next = 1'b1;
                obit_next = obit_reg + 3'h1;
                shout_next = {shout_reg[6:0], 1'b0};
                if (obit_reg == 3'h7) begin
                    shout_next = status_now;
                end
            end
        end
        busy_next = (timer_next != 32'h0) | op_busy_next;
        hpm_next = nv_next.status_lock_bit & ~wp_n_s;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            sck_d_reg <= 1'b0;
            cs_d_reg <= 1'b1;
            phase_reg <= fsp_pkg::PH_CMD;
            bit_reg <= 3'h0;
            obit_reg <= 3'h0;
            shin_reg <= 8'h00;
            shout_reg <= 8'h00;
            data_reg <= 8'h00;
            armed_reg <= 1'b0;
            timer_reg <= 32'h0;
            op_busy_reg <= 1'b0;
            wel_reg <= 1'b0;
            nv_reg <= {`FSP_RESET_LOCK, `FSP_RESET_BOTTOM, `FSP_RESET_SIZE};
            o_spi_miso <= 1'b0;
            o_spi_miso_oe <= 1'b0;
            o_op_grant <= 1'b0;
            o_op_reject <= 1'b0;
            o_write_busy_flag <= 1'b0;
            o_write_enable_latch <= 1'b0;
            o_hardware_locked_mode <= 1'b0;
            o_protect <= {`FSP_RESET_LOCK, `FSP_RESET_BOTTOM, `FSP_RESET_SIZE};
        end else begin
            sck_d_reg <= sck_d_next;
            cs_d_reg <= cs_d_next;
            phase_reg <= phase_next;
            bit_reg <= bit_next;
            obit_reg <= obit_next;
            shin_reg <= shin_next;
            shout_reg <= shout_next;
            data_reg <= data_next;
            armed_reg <= armed_next;
            timer_reg <= timer_next;
            op_busy_reg <= op_busy_next;
            wel_reg <= wel_next;
            nv_reg <= nv_next;
            o_spi_miso <= miso_next;
            o_spi_miso_oe <= oe_next;
            o_op_grant <= grant_next;
            o_op_reject <= reject_next;
            o_write_busy_flag <= busy_next;
            o_write_enable_latch <= wel_next;
            o_hardware_locked_mode <= hpm_next;
            o_protect <= nv_next;
        end
    end
endmodule // fsp_status_protect

`default_nettype wire

// [src/fsp_map.svh]
// Constants of the flash status and protection block.
// Assumes a 100 MHz system clock; included by bare name.
`ifndef FSP_MAP_SVH
`define FSP_MAP_SVH

`define FSP_CMD_READ_STATUS 8'h05
`define FSP_CMD_WRITE_STATUS 8'h01

`define FSP_BIT_BUSY 0
`define FSP_BIT_WEL 1
`define FSP_BIT_SIZE_LSB 2
`define FSP_BIT_SIZE_MSB 4
`define FSP_BIT_BOTTOM 5
`define FSP_BIT_LOCK 7

`define FSP_RESET_SIZE 3'h0
`define FSP_RESET_BOTTOM 1'b0
`define FSP_RESET_LOCK 1'b0

`define FSP_CLK_MHZ 100
`define FSP_WRITE_TIME_US 15
`define FSP_WRITE_CYCLES (`FSP_WRITE_TIME_US * `FSP_CLK_MHZ)

`endif

// [src/fsp_pkg.sv]
// Types of the flash status and protection block.
// Used with full package scope, never imported.
package fsp_pkg;

    typedef enum logic [1:0] {
        PH_CMD = 2'b00,
        PH_READ = 2'b01,
        PH_WDATA = 2'b10,
        PH_SKIP = 2'b11
    } fsp_phase_e;

    typedef enum logic [1:0] {
        OP_PAGE_PROGRAM = 2'b00,
        OP_SECTOR_ERASE = 2'b01,
        OP_SUBSECTOR_ERASE = 2'b10,
        OP_BULK_ERASE = 2'b11
    } fsp_op_e;

    typedef struct packed {
        logic status_lock_bit;
        logic protect_from_bottom;
        logic [2:0] protect_size;
    } fsp_nv_s;

endpackage

// [src/fsp_sync2.sv]
// Two-flop synchroniser for one asynchronous level.
// Assumes the input may change at any time relative to i_clk.
`timescale 1ns/1ns
`default_nettype none

module fsp_sync2 #(
    parameter logic RESET_VAL = 1'b0
) (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_async,
    output logic o_sync
);
    logic meta_reg;
    logic meta_next;
    logic sync_next;

    always_comb begin
        meta_next = i_async;
        sync_next = meta_reg;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_reg <= RESET_VAL;
            o_sync <= RESET_VAL;
        end else begin
            meta_reg <= meta_next;
            o_sync <= sync_next;
        end
    end
endmodule // fsp_sync2

`default_nettype wire

// [bench/fsp_host_model.sv]
// Host end of the serial link, mode 0, one frame per call.
// Assumes the bench calls frame() and wants sck idle between frames.
`timescale 1ns/1ns
`default_nettype none

module fsp_host_model (
    output logic o_sck,
    output logic o_cs_n,
    output logic o_mosi,
    input wire logic i_miso,
    input wire logic i_miso_oe
);
    initial begin
        o_sck = 1'b0;
        o_cs_n = 1'b1;
        o_mosi = 1'b0;
    end

    // Select held low through every bit sent or read
    task automatic frame(input logic [31:0] tx, input int n, output logic [31:0] rx);
        rx = 32'h0;
        o_cs_n = 1'b0;
        for (int b = n - 1; b >= 0; b--) begin
            o_mosi = tx[b];
            #80 o_sck = 1'b1;
            // Undriven line reads inverted so a late enable shows up
            rx = {rx[30:0], i_miso_oe ? i_miso : ~i_miso};
            #80 o_sck = 1'b0;
        end
        // Released line flips so no stale bit looks valid
        o_mosi = ~o_mosi;
        #80 o_cs_n = 1'b1;
        #100;
    endtask
endmodule // fsp_host_model

`default_nettype wire

// [bench/fsp_status_protect_properties.sv]
// Port checker of the flash status and protection block.
// Assumes it is bound to every fsp_status_protect instance.
`timescale 1ns/1ns
`default_nettype none

module fsp_status_protect_properties (
    input wire logic i_clk,
    input wire logic i_reset_n,
    input wire logic i_spi_cs_n,
    input wire logic i_op_req,
    input wire fsp_pkg::fsp_op_e i_op_kind,
    input wire logic o_spi_miso_oe,
    input wire logic o_op_grant,
    input wire logic o_op_reject,
    input wire logic o_write_busy_flag,
    input wire logic o_write_enable_latch,
    input wire logic o_hardware_locked_mode,
    input wire fsp_pkg::fsp_nv_s o_protect
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_reset_n);

    answer_once_a: assert property (i_op_req |=> o_op_grant ^ o_op_reject)
        else $error("request not answered exactly once");
    grant_cause_a: assert property (o_op_grant |-> $past(o_write_enable_latch)
        && !$past(o_write_busy_flag)) else $error("grant without latch or while busy");
    grant_busy_a: assert property (o_op_grant |-> o_write_busy_flag)
        else $error("grant without busy");
    latch_clear_a: assert property ($fell(o_write_busy_flag) |-> !o_write_enable_latch)
        else $error("latch kept after cycle end");
    bulk_guard_a: assert property (i_op_req && i_op_kind == fsp_pkg::OP_BULK_ERASE
        && o_protect.protect_size != 3'h0 |=> o_op_reject) else $error("bulk erase let through");
    full_guard_a: assert property (i_op_req && o_protect.protect_size == 3'h7
        |=> o_op_reject) else $error("op inside shield let through");
    lock_mode_a: assert property (o_hardware_locked_mode |-> o_protect.status_lock_bit)
        else $error("locked mode without lock bit");
    lock_freeze_a: assert property (o_hardware_locked_mode && $past(o_hardware_locked_mode)
        |-> $stable(o_protect)) else $error("bits changed while locked");
    nv_change_a: assert property ($changed(o_protect) |-> $past(o_write_enable_latch))
        else $error("protect bits changed without latch");
    read_idle_a: assert property (i_spi_cs_n [*6] |-> !o_spi_miso_oe)
        else $error("miso driven while deselected");

    cover property (o_op_grant);
    cover property (o_op_reject && o_protect.protect_size != 3'h0);
    cover property ($fell(o_hardware_locked_mode));
endmodule // fsp_status_protect_properties

bind fsp_status_protect fsp_status_protect_properties i_fsp_status_protect_properties (
    .i_clk(i_clk), .i_reset_n(i_reset_n), .i_spi_cs_n(i_spi_cs_n), .i_op_req(i_op_req),
    .i_op_kind(i_op_kind), .o_spi_miso_oe(o_spi_miso_oe), .o_op_grant(o_op_grant),
    .o_op_reject(o_op_reject), .o_write_busy_flag(o_write_busy_flag),
    .o_write_enable_latch(o_write_enable_latch),
    .o_hardware_locked_mode(o_hardware_locked_mode), .o_protect(o_protect));

`default_nettype wire

// [bench/tb.sv]
// Self-checking bench of the flash status and protection block.
// Assumes the host model drives the link; write time cut to 400 clocks.
`timescale 1ns/1ns
`default_nettype none

module tb;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic wp_n = 1'b1;
    logic wen = 1'b0;
    logic wdis = 1'b0;
    logic req = 1'b0;
    logic done = 1'b0;
    fsp_pkg::fsp_op_e kind = fsp_pkg::OP_PAGE_PROGRAM;
    logic [21:0] addr = 22'h0;
    logic sck, cs_n, mosi, miso, oe, grant, reject, busy, write_enable_latch, locked;
    fsp_pkg::fsp_nv_s prot;
    logic [31:0] rx;
    int n_fail = 0;
    int num_checks = 0;

    always #5 clk = ~clk;

    fsp_status_protect #(.WRITE_CYCLES(400)) i_fsp_status_protect (
        .i_clk(clk), .i_reset_n(rst_n), .i_spi_sck(sck), .i_spi_cs_n(cs_n),
        .i_spi_mosi(mosi), .i_write_protect_n(wp_n), .o_spi_miso(miso),
        .o_spi_miso_oe(oe), .i_write_enable(wen), .i_write_disable(wdis),
        .i_op_req(req), .i_op_kind(kind), .i_op_addr(addr), .i_op_done(done),
        .o_op_grant(grant), .o_op_reject(reject), .o_write_busy_flag(busy),
        .o_write_enable_latch(write_enable_latch), .o_hardware_locked_mode(locked), .o_protect(prot));

    fsp_host_model i_fsp_host_model (.o_sck(sck), .o_cs_n(cs_n), .o_mosi(mosi), .i_miso(miso),
        .i_miso_oe(oe));

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic results();
        $display("checks=%0d fails=%0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic tick();
        @(posedge clk);
        #1;
    endtask

    task automatic pulse(ref logic s);
        tick();
        s = 1'b1;
        tick();
        s = 1'b0;
    endtask

    task automatic rd(input int nb);
        i_fsp_host_model.frame(32'h05 << (8 * nb), 8 + 8 * nb, rx);
    endtask

    task automatic wsr(input logic [7:0] d);
        pulse(wen);
        i_fsp_host_model.frame({16'h0, 8'h01, d}, 16, rx);
    endtask

    task automatic wait_idle();
        int k;
        for (k = 0; k < 2000 && busy !== 1'b0; k++) tick();
        if (k == 2000) begin
            n_fail++;
            results();
        end
    endtask

    // Request with the latch set first; answer seen one cycle later
    task automatic op(input fsp_pkg::fsp_op_e k, input logic [21:0] a, input logic g);
        pulse(wen);
        tick();
        req = 1'b1;
        kind = k;
        addr = a;
        tick();
        req = 1'b0;
        check({6'h0, grant, reject}, {6'h0, g, !g});
    endtask

    task automatic finish_op();
        pulse(done);
        check({6'h0, write_enable_latch, busy}, 8'h0);
    endtask

    task automatic t_busy();
        tick();
        req = 1'b1;
        tick();
        req = 1'b0;
        check(8'(reject), 8'h1);
        pulse(wen);
        rd(1);
        check(rx[7:0], 8'h02);
        op(fsp_pkg::OP_SECTOR_ERASE, 22'h0, 1'b1);
        op(fsp_pkg::OP_SUBSECTOR_ERASE, 22'h0, 1'b0);
        rd(2);
        check(rx[15:8], 8'h03);
        check(rx[7:0], 8'h03);
        i_fsp_host_model.frame({16'h0, 8'h01, 8'h9c}, 16, rx);
        check({2'h0, busy, prot}, 8'h20);
        finish_op();
        pulse(wen);
        pulse(wdis);
        check(8'(write_enable_latch), 8'h0);
        i_fsp_host_model.frame({16'h0, 8'h01, 8'h9c}, 16, rx);
        check({2'h0, busy, prot}, 8'h00);
        pulse(wen);
        i_fsp_host_model.frame({15'h0, 8'h01, 8'h9c, 1'b0}, 17, rx);
        check({2'h0, busy, prot}, 8'h00);
        $display("busy test done");
    endtask

    // Spare, busy and latch bits of the data are ignored by the write
    task automatic t_write();
        wsr(8'hff);
        rd(1);
        check(rx[7:0], 8'hbf);
        wait_idle();
        rd(2);
        check(rx[15:8], 8'hbc);
        check(rx[7:0], 8'hbc);
        op(fsp_pkg::OP_PAGE_PROGRAM, 22'h0, 1'b0);
        op(fsp_pkg::OP_BULK_ERASE, 22'h0, 1'b0);
        $display("write test done");
    endtask

    task automatic t_lock();
        wp_n = 1'b0;
        repeat (5) tick();
        check(8'(locked), 8'h1);
        wsr(8'h00);
        wait_idle();
        check({3'h0, prot}, 8'h1f);
        wp_n = 1'b1;
        repeat (5) tick();
        check(8'(locked), 8'h0);
        wsr(8'h04);
        wait_idle();
        check({3'h0, prot}, 8'h01);
        $display("lock test done");
    endtask

    task automatic t_region();
        op(fsp_pkg::OP_PAGE_PROGRAM, 22'h3fffff, 1'b0);
        op(fsp_pkg::OP_PAGE_PROGRAM, 22'h0, 1'b1);
        finish_op();
        wsr(8'h24);
        wait_idle();
        check({3'h0, prot}, 8'h09);
        op(fsp_pkg::OP_PAGE_PROGRAM, 22'h0, 1'b0);
        op(fsp_pkg::OP_BULK_ERASE, 22'h0, 1'b0);
        $display("region test done");
    endtask

    initial begin
        repeat (3) @(posedge clk);
        #1 rst_n = 1'b1;
        check({3'h0, prot}, 8'h00);
        repeat (3) tick();
        rd(1);
        check(rx[7:0], 8'h00);
        t_busy();
        t_write();
        t_lock();
        t_region();
        results();
    end
endmodule // tb

`default_nettype wire
